//--- hw/tcc_timer16.v
// 16-bit timer capture and compare block with apb registers
//
// Overview of operation
// - capture copies counter and sets flag together
// - capture flag interrupt; clears on service or one
// - low read latches capture high byte
// - capture writable only in capture-top modes
// - comparator select switches trigger source
// - filter needs four equal samples
// - capture ignored in capture-top modes
// - software pin drive captures like external
// - each capture overwrites previous value
// - compare flag interrupt; clears on service or one
// - compare a may define counter top
// - pwm modes double buffer, update at top/bottom
// - pwm-mode writes reach buffer; compare reads direct
// - high write latches; low write commits word
// - force updates output in non-pwm modes only, no flag, no clear
// - counter write blocks next tick's match
// - output state survives mode change
// - output action changes apply immediately
// - counter low read/write uses shared latch
// - action zero leaves output unchanged
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module tcc_timer16 (
    // apb
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // timer side
    input  wire        timer_tick,
    input  wire        capture_pin,
    input  wire        comparator_output,
    // interrupt service acknowledges
    input  wire        capture_irq_ack,
    input  wire [2:0]  compare_irq_ack,
    // outputs
    output wire        capture_irq,
    output wire [2:0]  compare_irq,
    output wire [2:0]  compare_output,
    output wire [15:0] timer_count
);
`include "tcc_defines.vh"
    reg  [31:0] ctrl_r;
    reg  [15:0] cnt_r;
    reg  [15:0] cap_r;
    reg  [7:0]  temp_r;
    reg         cap_flag_r;
    reg  [2:0]  cmp_flag_r;
    reg  [2:0]  oc_r;
    reg  [47:0] cmp_r;
    reg  [47:0] buf_r;
    reg         block_r;
    wire [3:0]  wgm;
    wire        cap_top;
    wire        pwm;
    wire        cmpa_top;
    wire [15:0] top;
    wire        at_top;
    wire        at_bot;
    wire        wr;
    wire        rd;
    wire        cnt_wr;
    wire        cap_ev;
    wire [2:0]  match;
    wire [2:0]  force_w;
    wire [47:0] cmp_view;
    integer     i;

    assign wgm     = ctrl_r[`TCC_CTRL_WGM_LSB+3:`TCC_CTRL_WGM_LSB];
    assign cap_top = (wgm == `TCC_MODE_CTC_CAP) ||
                     (wgm == `TCC_MODE_FPWM_CAP) ||
                     (wgm == `TCC_MODE_PWM_CAP) ||
                     (wgm == `TCC_MODE_PFC_CAP);
    // normal, both clear-on-match modes and reserved are not pwm
    assign pwm = (wgm != `TCC_MODE_NORMAL) &&
                 (wgm != `TCC_MODE_CTC_CMP) &&
                 (wgm != `TCC_MODE_CTC_CAP) &&
                 (wgm != `TCC_MODE_RSV);
    assign cmpa_top = (wgm == `TCC_MODE_CTC_CMP) ||
                      (wgm == 4'h9) || (wgm == 4'hB) ||
                      (wgm == 4'hF);
    assign top = cmpa_top ? cmp_r[15:0] : cap_top ? cap_r : 16'hFFFF;
    assign at_top = (cnt_r == top);
    assign at_bot = (cnt_r == 16'h0000);

    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign cnt_wr = wr && (paddr == `TCC_OFF_CNT_LOW);
    assign timer_count = cnt_r;

    tcc_capture_front u_front (
        .pclk                      (pclk),
        .presetn                   (presetn),
        .capture_pin               (capture_pin),
        .comparator_output         (comparator_output),
        .comparator_capture_select (ctrl_r[`TCC_CTRL_COMPARATOR_CAPTURE_SELECT_BIT]),
        .filter_enable             (ctrl_r[`TCC_CTRL_FILT_BIT]),
        .edge_rising               (ctrl_r[`TCC_CTRL_EDGE_BIT]),
        .capture_block             (cap_top),
        .capture_event             (cap_ev)
    );

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_cmp
            // blocked in the tick after a counter write
            assign match[g] = timer_tick && !block_r &&
                              (cnt_r == cmp_r[g*16+15:g*16]);
            assign force_w[g] = wr && !pwm &&
                                (paddr == `TCC_OFF_FORCE) && pwdata[g];
        end
    endgenerate

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r     <= `TCC_CTRL_RESET;
            cnt_r      <= 16'h0000;
            cap_r      <= 16'h0000;
            temp_r     <= 8'h00;
            cap_flag_r <= 1'b0;
            cmp_flag_r <= 3'h0;
            oc_r       <= 3'h0;
            cmp_r      <= 48'h0;
            buf_r      <= 48'h0;
            block_r    <= 1'b0;
        end else begin
            // held across stopped clock until the next tick
            if (cnt_wr) begin
                block_r <= 1'b1;
            end else if (timer_tick) begin
                block_r <= 1'b0;
            end
            // software write has priority over counting
            if (cnt_wr) begin
                cnt_r <= {temp_r, pwdata[7:0]};
            end else if (timer_tick) begin
                if (at_top && top != 16'hFFFF) begin
                    cnt_r <= 16'h0000;
                end else begin
                    cnt_r <= cnt_r + 16'h0001;
                end
            end
            if (cap_ev) begin
                cap_r      <= cnt_r;
            end else if (wr && cap_top &&
                         paddr == `TCC_OFF_CAP_LOW) begin
                cap_r <= {temp_r, pwdata[7:0]};
            end
            // set wins over clear
            if (cap_ev) begin
                cap_flag_r <= 1'b1;
            end else if (capture_irq_ack ||
                         (wr && paddr == `TCC_OFF_STATUS &&
                          pwdata[`TCC_STAT_CAP_BIT])) begin
                cap_flag_r <= 1'b0;
            end
            for (i = 0; i < 3; i = i + 1) begin
                if (match[i]) begin
                    cmp_flag_r[i] <= 1'b1;
                end else if (compare_irq_ack[i] ||
                             (wr && paddr == `TCC_OFF_STATUS &&
                              pwdata[`TCC_STAT_CMP_LSB+i])) begin
                    cmp_flag_r[i] <= 1'b0;
                end
                // action read live, never buffered
                if (match[i] || force_w[i]) begin
                    case (ctrl_r[`TCC_CTRL_ACT_LSB+2*i+:2])
                        2'h1: oc_r[i] <= ~oc_r[i];
                        2'h2: oc_r[i] <= 1'b0;
                        2'h3: oc_r[i] <= 1'b1;
                        default: oc_r[i] <= oc_r[i];
                    endcase
                end
                if (wr && paddr == `TCC_OFF_CMPA_LOW + 8*i) begin
                    if (pwm) begin
                        buf_r[i*16+:16] <= {temp_r, pwdata[7:0]};
                    end else begin
                        cmp_r[i*16+:16] <= {temp_r, pwdata[7:0]};
                    end
                end else if (pwm && timer_tick && (at_top || at_bot)) begin
                    cmp_r[i*16+:16] <= buf_r[i*16+:16];
                end
            end
            if (wr && (paddr == `TCC_OFF_CMPA_HIGH ||
                       paddr == `TCC_OFF_CMPB_HIGH ||
                       paddr == `TCC_OFF_CMPC_HIGH ||
                       paddr == `TCC_OFF_CAP_HIGH ||
                       paddr == `TCC_OFF_CNT_HIGH)) begin
                temp_r <= pwdata[7:0];
            end else if (rd && paddr == `TCC_OFF_CNT_LOW) begin
                temp_r <= cnt_r[15:8];
            end else if (rd && paddr == `TCC_OFF_CAP_LOW) begin
                temp_r <= cap_r[15:8];
            end
            if (wr && paddr == `TCC_OFF_CTRL) begin
                ctrl_r <= {12'h000, pwdata[19:0]};
            end
        end
    end

    // buffer in pwm modes, active value otherwise
    assign cmp_view = pwm ? buf_r : cmp_r;

    // compare values read directly, without the latch
    always @* begin
        case (paddr)
            `TCC_OFF_CTRL:      prdata = ctrl_r;
            `TCC_OFF_STATUS:    prdata = {28'h0, cmp_flag_r, cap_flag_r};
            `TCC_OFF_CNT_LOW:   prdata = {24'h0, cnt_r[7:0]};
            `TCC_OFF_CNT_HIGH:  prdata = {24'h0, temp_r};
            `TCC_OFF_CAP_LOW:   prdata = {24'h0, cap_r[7:0]};
            `TCC_OFF_CAP_HIGH:  prdata = {24'h0, temp_r};
            `TCC_OFF_CMPA_LOW:  prdata = {24'h0, cmp_view[7:0]};
            `TCC_OFF_CMPA_HIGH: prdata = {24'h0, cmp_view[15:8]};
            `TCC_OFF_CMPB_LOW:  prdata = {24'h0, cmp_view[23:16]};
            `TCC_OFF_CMPB_HIGH: prdata = {24'h0, cmp_view[31:24]};
            `TCC_OFF_CMPC_LOW:  prdata = {24'h0, cmp_view[39:32]};
            `TCC_OFF_CMPC_HIGH: prdata = {24'h0, cmp_view[47:40]};
            default:            prdata = 32'h0000_0000;
        endcase
    end

    assign capture_irq = cap_flag_r && ctrl_r[`TCC_CTRL_CIE_BIT];
    assign compare_irq = cmp_flag_r &
                         ctrl_r[`TCC_CTRL_OIE_LSB+2:`TCC_CTRL_OIE_LSB];
    assign compare_output = oc_r;
endmodule // tcc_timer16

//--- hw/tcc_defines.vh
// register offsets, field positions, reset values and timing counts
`ifndef TCC_DEFINES_VH
`define TCC_DEFINES_VH
`define TCC_OFF_CTRL        12'h000
`define TCC_OFF_STATUS      12'h004
`define TCC_OFF_CNT_LOW     12'h008
`define TCC_OFF_CNT_HIGH    12'h00C
`define TCC_OFF_CAP_LOW     12'h010
`define TCC_OFF_CAP_HIGH    12'h014
`define TCC_OFF_CMPA_LOW    12'h018
`define TCC_OFF_CMPA_HIGH   12'h01C
`define TCC_OFF_CMPB_LOW    12'h020
`define TCC_OFF_CMPB_HIGH   12'h024
`define TCC_OFF_CMPC_LOW    12'h028
`define TCC_OFF_CMPC_HIGH   12'h02C
`define TCC_OFF_FORCE       12'h030
// control register fields
`define TCC_CTRL_WGM_LSB    0
`define TCC_CTRL_FILT_BIT   4
`define TCC_CTRL_EDGE_BIT   5
`define TCC_CTRL_COMPARATOR_CAPTURE_SELECT_BIT   6
`define TCC_CTRL_CLKEN_BIT  7
`define TCC_CTRL_ACT_LSB    8
`define TCC_CTRL_CIE_BIT    16
`define TCC_CTRL_OIE_LSB    17
`define TCC_CTRL_RESET      32'h0000_0000
// status fields: capture flag bit 0, compare flags bits 3:1
`define TCC_STAT_CAP_BIT    0
`define TCC_STAT_CMP_LSB    1
`define TCC_FILT_SAMPLES    4
`define TCC_MODE_NORMAL     4'h0
`define TCC_MODE_CTC_CMP    4'h4
`define TCC_MODE_CTC_CAP    4'hC
`define TCC_MODE_FPWM_CAP   4'hE
`define TCC_MODE_PWM_CAP    4'h8
`define TCC_MODE_PFC_CAP    4'hA
`define TCC_MODE_RSV        4'hD
`endif

//--- hw/tcc_capture_front.v
// capture trigger select, noise filter and edge detector
`timescale 1ns/1ps
module tcc_capture_front (
    // clock and reset
    input  wire pclk,
    input  wire presetn,
    // trigger sources
    input  wire capture_pin,
    input  wire comparator_output,
    // configuration
    input  wire comparator_capture_select,
    input  wire filter_enable,
    input  wire edge_rising,
    input  wire capture_block,
    // event
    output wire capture_event
);
`include "tcc_defines.vh"
    reg  [1:0] sync_r;
    // three held samples plus the live one make the full window
    reg  [`TCC_FILT_SAMPLES-2:0] hist_r;
    reg        filt_r;
    reg        prev_r;
    wire       src;
    wire       all_hi;
    wire       all_lo;
    wire       level;

    // pin level includes a software-driven port output
    assign src = comparator_capture_select ? comparator_output
                                           : capture_pin;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_r <= 2'h0;
            hist_r <= {(`TCC_FILT_SAMPLES-1){1'b0}};
            filt_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            sync_r <= {sync_r[0], src};
            hist_r <= {hist_r[`TCC_FILT_SAMPLES-3:0], sync_r[1]};
            if (all_hi) begin
                filt_r <= 1'b1;
            end else if (all_lo) begin
                filt_r <= 1'b0;
            end
            prev_r <= level;
        end
    end

    // live sample counts, so the filter costs exactly the window length
    assign all_hi = &{hist_r, sync_r[1]};
    assign all_lo = ~|{hist_r, sync_r[1]};
    // filter adds the extra sample delay only when enabled
    assign level = filter_enable ? filt_r : sync_r[1];
    // ignored in modes where capture register is top
    assign capture_event = !capture_block &&
        (edge_rising ? (level && !prev_r)
                     : (!level && prev_r));
endmodule // tcc_capture_front

//--- verif/tcc_timer16_props.sv
// assertion checker for the timer capture and compare block
`timescale 1ns/1ps
`include "tcc_defines.vh"
module tcc_timer16_props (
    // apb
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    // timer side
    input wire        timer_tick,
    input wire [2:0]  compare_irq,
    input wire [2:0]  compare_output,
    input wire [15:0] timer_count
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc   = psel && penable;
    wire cnt_w = acc && pwrite && paddr == `TCC_OFF_CNT_LOW;
    wire frc_w = acc && pwrite && paddr == `TCC_OFF_FORCE;
    // the first tick after the write, following one idle cycle, is the one that swallows the match
    sequence blocked_tick;
        cnt_w ##1 !timer_tick ##1 (timer_tick && !frc_w);
    endsequence
    AST_ZERO_WAIT: assert property (acc |-> pready)
        else $error("access phase without ready");
    AST_NO_ERR: assert property (acc |-> !pslverr)
        else $error("slave error raised");
    AST_UNMAPPED: assert property (acc && !pwrite && paddr == 12'h034
        |-> prdata == 32'h0000_0000) else $error("unmapped read not zero");
    AST_CNT_HOLD: assert property (!timer_tick && !cnt_w |=> $stable(timer_count))
        else $error("counter moved without tick or write");
    AST_CNT_STEP: assert property (timer_tick && !cnt_w |=>
        timer_count == $past(timer_count) + 16'h0001 || timer_count == 16'h0000)
        else $error("counter step wrong");
    AST_OUT_HOLD: assert property (!timer_tick && !frc_w |=> $stable(compare_output))
        else $error("compare output moved without cause");
    AST_WR_BLOCK: assert property (blocked_tick |=> $stable(compare_output))
        else $error("match not blocked after counter write");
    AST_IRQ_CAUSE: assert property ((compare_irq & ~$past(compare_irq)) != 3'h0
        |-> $past(timer_tick) || $past(acc && pwrite))
        else $error("compare irq rose without tick or write");
endmodule // tcc_timer16_props

//--- verif/tcc_event_src.sv
// far-side event source: capture pin and comparator output
`timescale 1ns/1ps
module tcc_event_src (
    // clock
    input  wire pclk,
    // event lines
    output reg  capture_pin,
    output reg  comparator_output
);
    initial capture_pin = 1'b0;
    initial comparator_output = 1'b0;
    // levels move just after an edge, as a port bit written by software
    task automatic drive(input bit src, input bit lvl);
        @(posedge pclk);
        if (src) comparator_output <= lvl;
        else capture_pin <= lvl;
    endtask
endmodule // tcc_event_src

//--- verif/tcc_timer16_tb.sv
// self-checking bench for the timer capture and compare block
`timescale 1ns/1ps
`include "tcc_defines.vh"
module tcc_timer16_tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic        timer_tick = 1'b0;
    logic        cap_ack = 1'b0;
    logic [2:0]  cmp_ack = 3'h0;
    wire  [31:0] prdata;
    wire         pready, pslverr, capture_pin, comparator_output, capture_irq;
    wire  [2:0]  compare_irq, compare_output;
    wire  [15:0] timer_count;
    logic [31:0] rv;
    int          fail_count = 0;
    int          n_checks = 0;
    int          lat0, lat1;
    always #5 pclk = ~pclk;
    tcc_event_src ev (.pclk(pclk), .capture_pin(capture_pin),
        .comparator_output(comparator_output));
    tcc_timer16 dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_tick(timer_tick), .capture_pin(capture_pin),
        .comparator_output(comparator_output), .capture_irq_ack(cap_ack),
        .compare_irq_ack(cmp_ack), .capture_irq(capture_irq),
        .compare_irq(compare_irq), .compare_output(compare_output),
        .timer_count(timer_count));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input bit w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rv = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // high byte first, low byte commits the word
    task automatic wr16(input logic [11:0] lo, input logic [15:0] v);
        apb(1'b1, lo + 12'h004, {24'h0, v[15:8]});
        apb(1'b1, lo, {24'h0, v[7:0]});
    endtask
    task automatic rd16(input logic [11:0] lo, input string nm, input logic [15:0] e);
        logic [7:0] t;
        apb(1'b0, lo, 32'h0);
        t = rv[7:0];
        apb(1'b0, lo + 12'h004, 32'h0);
        chk(nm, {16'h0, e}, {16'h0, rv[7:0], t});
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge pclk);
            timer_tick <= 1'b1;
            @(posedge pclk);
            timer_tick <= 1'b0;
        end
        @(negedge pclk);
    endtask
    // 30 means no capture seen while the line was high
    task automatic cap(input bit src, output int lat);
        ev.drive(src, 1'b1);
        lat = 0;
        while (capture_irq !== 1'b1 && lat < 30) begin
            @(posedge pclk);
            lat++;
        end
        ev.drive(src, 1'b0);
        repeat (12) @(posedge pclk);
    endtask
    task automatic t_capture();
        apb(1'b1, `TCC_OFF_CTRL, 32'h0001_0020);
        wr16(`TCC_OFF_CNT_LOW, 16'h1234);
        cap(1'b0, lat0);
        chk("cap_irq", 32'h1, capture_irq);
        rd16(`TCC_OFF_CAP_LOW, "cap", 16'h1234);
        rd16(`TCC_OFF_CNT_LOW, "cnt", 16'h1234);
        wr16(`TCC_OFF_CNT_LOW, 16'h5678);
        cap(1'b0, lat0);
        rd16(`TCC_OFF_CAP_LOW, "cap2", 16'h5678);
        apb(1'b1, `TCC_OFF_CTRL, 32'h0001_0000);
        apb(1'b1, `TCC_OFF_STATUS, 32'h1);
        cap(1'b0, lat0);
        chk("rise_ignored", 32'd30, lat0);
        chk("fall_irq", 32'h1, capture_irq);
        @(posedge pclk);
        cap_ack <= 1'b1;
        @(posedge pclk);
        cap_ack <= 1'b0;
        @(negedge pclk);
        chk("ack_clr", 32'h0, capture_irq);
        $display("test capture done");
    endtask
    task automatic t_filter();
        apb(1'b1, `TCC_OFF_CTRL, 32'h0001_0020);
        apb(1'b1, `TCC_OFF_STATUS, 32'h1);
        cap(1'b0, lat0);
        apb(1'b1, `TCC_OFF_CTRL, 32'h0001_0030);
        apb(1'b1, `TCC_OFF_STATUS, 32'h1);
        cap(1'b0, lat1);
        chk("filter_delay", 32'd4, lat1 - lat0);
        apb(1'b1, `TCC_OFF_CTRL, 32'h0001_0060);
        apb(1'b1, `TCC_OFF_STATUS, 32'h1);
        cap(1'b1, lat0);
        chk("comp_src", 32'h1, capture_irq);
        $display("test filter done");
    endtask
    task automatic t_top_mode();
        apb(1'b1, `TCC_OFF_CTRL, {16'h0001, 12'h002, `TCC_MODE_CTC_CAP});
        apb(1'b1, `TCC_OFF_STATUS, 32'h1);
        wr16(`TCC_OFF_CAP_LOW, 16'h00AB);
        cap(1'b0, lat0);
        chk("top_ignored", 32'd30, lat0);
        rd16(`TCC_OFF_CAP_LOW, "cap_top", 16'h00AB);
        apb(1'b1, `TCC_OFF_CTRL, 32'h0001_0020);
        wr16(`TCC_OFF_CAP_LOW, 16'h0099);
        rd16(`TCC_OFF_CAP_LOW, "cap_ro", 16'h00AB);
        $display("test top mode done");
    endtask
    task automatic t_compare();
        apb(1'b1, `TCC_OFF_CTRL, 32'h0002_0100);
        wr16(`TCC_OFF_CMPA_LOW, 16'h0110);
        apb(1'b1, `TCC_OFF_CNT_HIGH, 32'h77);
        apb(1'b0, `TCC_OFF_CMPA_HIGH, 32'h0);
        chk("cmp_direct", 32'h01, rv & 32'hFF);
        wr16(`TCC_OFF_CNT_LOW, 16'h010F);
        ticks(2);
        chk("match_out", 32'h1, compare_output);
        chk("match_irq", 32'h1, compare_irq);
        @(posedge pclk);
        cmp_ack <= 3'h1;
        @(posedge pclk);
        cmp_ack <= 3'h0;
        @(negedge pclk);
        chk("cmp_ack", 32'h0, compare_irq);
        wr16(`TCC_OFF_CNT_LOW, 16'h0110);
        ticks(1);
        chk("blocked_out", 32'h1, compare_output);
        apb(1'b1, `TCC_OFF_FORCE, 32'h1);
        @(negedge pclk);
        chk("force_out", 32'h0, compare_output);
        apb(1'b0, `TCC_OFF_STATUS, 32'h0);
        chk("no_flag", 32'h0, rv);
        apb(1'b1, `TCC_OFF_FORCE, 32'h1);
        apb(1'b1, `TCC_OFF_CTRL, {20'h00020, 8'h01, `TCC_MODE_FPWM_CAP});
        @(negedge pclk);
        chk("mode_keep", 32'h1, compare_output);
        apb(1'b1, `TCC_OFF_CTRL, 32'h0002_0000);
        wr16(`TCC_OFF_CNT_LOW, 16'h010F);
        ticks(2);
        chk("act_zero", 32'h1, compare_output);
        chk("act_zero_irq", 32'h1, compare_irq);
        $display("test compare done");
    endtask
    task automatic t_top_buffer();
        apb(1'b1, `TCC_OFF_STATUS, 32'hF);
        apb(1'b1, `TCC_OFF_CTRL, {28'h0, `TCC_MODE_CTC_CMP});
        wr16(`TCC_OFF_CMPA_LOW, 16'h0020);
        wr16(`TCC_OFF_CNT_LOW, 16'h001F);
        ticks(2);
        chk("cmpa_top", 32'h0, timer_count);
        apb(1'b0, `TCC_OFF_STATUS, 32'h0);
        chk("cmp_flag", 32'h2, rv & 32'hE);
        apb(1'b1, `TCC_OFF_STATUS, 32'h2);
        apb(1'b0, `TCC_OFF_STATUS, 32'h0);
        chk("cmp_w1c", 32'h0, rv & 32'hE);
        apb(1'b1, `TCC_OFF_CTRL, 32'h0000_000F);
        wr16(`TCC_OFF_CMPB_LOW, 16'h0005);
        apb(1'b1, `TCC_OFF_CTRL, 32'h0);
        rd16(`TCC_OFF_CMPB_LOW, "cmpb_held", 16'h0000);
        apb(1'b1, `TCC_OFF_CTRL, 32'h0000_000F);
        wr16(`TCC_OFF_CNT_LOW, 16'h0000);
        ticks(1);
        apb(1'b1, `TCC_OFF_CTRL, 32'h0);
        rd16(`TCC_OFF_CMPB_LOW, "cmpb_loaded", 16'h0005);
        $display("test top and buffer done");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #500000;
        fail_count++;
        tally_and_finish();
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `TCC_OFF_CTRL, 32'h0);
        chk("ctrl_rst", `TCC_CTRL_RESET, rv);
        apb(1'b0, 12'h034, 32'h0);
        chk("unmapped", 32'h0, rv);
        t_capture();
        t_filter();
        t_top_mode();
        t_compare();
        t_top_buffer();
        tally_and_finish();
    end
endmodule // tcc_timer16_tb
bind tcc_timer16 tcc_timer16_props u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_tick(timer_tick), .compare_irq(compare_irq),
    .compare_output(compare_output), .timer_count(timer_count));
